/* key_build_pkg.sv */
/*
  Constants shared by the key field builder: bitmap layout, tag codes,
  flag thresholds and the register map.
  Assumes one 40 MHz core clock and a zero-or-one-wait AHB-Lite master.

// Notes on behaviour
// - Selector 0: 53-bit bitmap has only the physical ingress port bit set.
// - Selector 1: bitmap bit of the port the frame looped on is set.
// - Selector 2: bitmap bit of the masqueraded source port is set.
// - Selector 3: bits 0-3 flag source CPU port 1/2, virtual device 1/2.
// - Selector 3: source port number, maybe masqueraded, sits in bits 4-9.
// - Selector 3: pipeline point in 44-48, action in 49-51, bit 52 reserved.
// - Group flag follows bit 40 of the destination MAC.
// - Broadcast flag only for an all-ones destination MAC.
// - Outer tag code: 0 none, 1 C-tag, 4 S-tag, 5-7 custom values.
// - Second tag uses the same codes, 0 when absent.
// - Third tag uses the same codes, 0 when absent.
// - Outer priority, drop bit, VLAN from frame, or classified when enabled.
// - Untagged frames give an outer VLAN ID of zero.
// - Second and third tag fields come straight from the frame.
// - IP group flag: IPv4 top nibble 0xe, IPv6 top byte 0xff.
// - Type-encoded flag set when type/length is at least 0x600.
// - Loopback frames get selector 1.
// - Several qualifying selector values: the highest one wins.
*/
`default_nettype none

package key_build_pkg;
  localparam int PORT_CNT = 53;
  localparam int PORT_W = 6;
  localparam int BM_FIRST_CPU = 0;
  localparam int BM_SECOND_CPU = 1;
  localparam int BM_FIRST_VD = 2;
  localparam int BM_SECOND_VD = 3;
  localparam int BM_SRC_LO = 4;
  localparam int BM_SRC_HI = 9;
  localparam int BM_PT_LO = 44;
  localparam int BM_PT_HI = 48;
  localparam int BM_ACT_LO = 49;
  localparam int BM_ACT_HI = 51;
  localparam int BM_RSVD = 52;
  localparam logic [1:0] SEL_PHYS = 2'h0;
  localparam logic [1:0] SEL_LOOP = 2'h1;
  localparam logic [1:0] SEL_MASQ = 2'h2;
  localparam logic [1:0] SEL_SPECIAL = 2'h3;
  localparam logic [15:0] TPID_CTAG = 16'h8100;
  localparam logic [15:0] TPID_STAG = 16'h88a8;
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_CTAG = 3'h1;
  localparam logic [2:0] CODE_STAG = 3'h4;
  localparam logic [2:0] CODE_CUST1 = 3'h5;
  localparam logic [2:0] CODE_CUST2 = 3'h6;
  localparam logic [2:0] CODE_CUST3 = 3'h7;
  localparam int MAC_GROUP_BIT = 40;
  localparam logic [15:0] TYPE_MIN = 16'h0600;
  localparam logic [3:0] IP4_MC_NIBBLE = 4'he;
  localparam logic [7:0] IP6_MC_BYTE = 8'hff;
  // Register map, byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CUST12 = 8'h04;
  localparam logic [7:0] OFS_CUST3 = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam int CTRL_USE_CL = 0;
  localparam int CTRL_MASQ_ENA = 1;
  localparam int CTRL_CPU_ENA = 2;
  localparam int CTRL_VD_ENA = 3;
  localparam int CTRL_LBK3_ENA = 4;
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  localparam logic [15:0] CUST_RESET = 16'h0000;
endpackage : key_build_pkg

`default_nettype wire

/* tag_code_if.sv */
/*
  Carrier between the key builder and one tag code encoder.
  Assumes the builder drives the tag inputs and reads the code.
*/
`default_nettype none

interface tag_code_if;
  logic present;
  logic [15:0] tpid;
  logic [2:0] code;
  modport enc (input present, input tpid, output code);
  modport user (output present, output tpid, input code);
endinterface : tag_code_if

`default_nettype wire

/* tag_code_enc.sv */
/*
  Maps one tag's protocol identifier to its 3-bit key code.
  Assumes the custom values come from registers in the same clock domain.
*/
`default_nettype none

module tag_code_enc
  import key_build_pkg::*;
(
  tag_code_if.enc tag,
  input wire logic [15:0] cust1_i,
  input wire logic [15:0] cust2_i,
  input wire logic [15:0] cust3_i
);
  // Fixed identifiers win over custom ones that happen to equal them.
  // An unknown identifier counts as no tag, so codes 2 and 3 never
  // appear.
  assign tag.code = !tag.present ? CODE_NONE :
                    (tag.tpid == TPID_CTAG) ? CODE_CTAG :
                    (tag.tpid == TPID_STAG) ? CODE_STAG :
                    (tag.tpid == cust1_i) ? CODE_CUST1 :
                    (tag.tpid == cust2_i) ? CODE_CUST2 :
                    (tag.tpid == cust3_i) ? CODE_CUST3 :
                    CODE_NONE;
endmodule : tag_code_enc

`default_nettype wire

/* key_field_builder.sv */
/*
  Builds the port bitmap, L2 flags, tag and MAC fields of the lookup key
  from one parsed frame, plus an AHB-Lite register slave for its setup.
  Assumes the parser gives all frame fields with a one-cycle valid pulse,
  and that the lookup stage takes the key one cycle later.
*/
`default_nettype none

module key_field_builder
  import key_build_pkg::*;
#(
  parameter logic [PORT_W-1:0] FIRST_CPU_PORT = 6'h35,
  parameter logic [PORT_W-1:0] SECOND_CPU_PORT = 6'h36,
  parameter logic [PORT_W-1:0] FIRST_VD_PORT = 6'h37,
  parameter logic [PORT_W-1:0] SECOND_VD_PORT = 6'h38,
  parameter logic [2:0] ACT_INJ_MASQ = 3'h1
)
(
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic FRAME_VALID_I,
  input wire logic [key_build_pkg::PORT_W-1:0] PHYS_PORT_I,
  input wire logic LOOPBACK_I,
  input wire logic [key_build_pkg::PORT_W-1:0] LOOP_PORT_I,
  input wire logic INJECT_I,
  input wire logic CPU_INJECT_I,
  input wire logic [key_build_pkg::PORT_W-1:0] SRC_PORT_I,
  input wire logic [4:0] PIPELINE_PT_I,
  input wire logic [2:0] PIPELINE_ACT_I,
  input wire logic [47:0] DEST_MAC_I,
  input wire logic [47:0] SRC_MAC_I,
  input wire logic [2:0] TAG_PRESENT_I,
  input wire logic [2:0][15:0] TAG_TPID_I,
  input wire logic [2:0][15:0] TAG_TCI_I,
  input wire logic [2:0] CL_PCP_I,
  input wire logic CL_DEI_I,
  input wire logic [11:0] CL_VID_I,
  input wire logic [15:0] ETYPE_I,
  input wire logic IS_IP4_I,
  input wire logic IS_IP6_I,
  input wire logic [7:0] DIP_TOP_I,
  output logic KEY_VALID_O,
  output logic [key_build_pkg::PORT_CNT-1:0] INGRESS_PORT_BITMAP_O,
  output logic [1:0] PORT_BITMAP_SELECTOR_O,
  output logic DEST_MAC_GROUP_FLAG_O,
  output logic DEST_MAC_BROADCAST_FLAG_O,
  output logic [2:0] OUTER_TAG_PROTO_CODE_O,
  output logic [2:0] OUTER_TAG_PRIORITY_O,
  output logic OUTER_TAG_DROP_ELIGIBLE_O,
  output logic [11:0] OUTER_TAG_VLAN_ID_O,
  output logic [2:0] SECOND_TAG_PROTO_CODE_O,
  output logic [2:0] SECOND_TAG_PRIORITY_O,
  output logic SECOND_TAG_DROP_ELIGIBLE_O,
  output logic [11:0] SECOND_TAG_VLAN_ID_O,
  output logic [2:0] THIRD_TAG_PROTO_CODE_O,
  output logic [2:0] THIRD_TAG_PRIORITY_O,
  output logic THIRD_TAG_DROP_ELIGIBLE_O,
  output logic [11:0] THIRD_TAG_VLAN_ID_O,
  output logic [47:0] DEST_MAC_FIELD_O,
  output logic [47:0] SRC_MAC_FIELD_O,
  output logic IP_GROUP_DEST_FLAG_O,
  output logic TYPE_ENCODED_FLAG_O
);
  import key_build_pkg::*;

  // One bit per port; numbers past the last port give an empty map
  function automatic logic [PORT_CNT-1:0] port_bit(
    input logic [PORT_W-1:0] port);
    port_bit = {{(PORT_CNT-1){1'b0}}, 1'b1} << port;
  endfunction : port_bit

  logic [CTRL_W-1:0] ctrl_q;
  logic [15:0] cust1_q;
  logic [15:0] cust2_q;
  logic [15:0] cust3_q;
  logic [15:0] key_cnt_q;
  logic wr_q;
  logic rd_q;
  logic [7:0] addr_q;

  // ---- AHB-Lite slave ----
  // Reads take one wait state so a write just before is already stored.
  wire access = HSEL_I && HTRANS_I[1] && HREADY_I;
  wire use_cl = ctrl_q[CTRL_USE_CL];
  wire masq_ena = ctrl_q[CTRL_MASQ_ENA];
  wire cpu_ena = ctrl_q[CTRL_CPU_ENA];
  wire vd_ena = ctrl_q[CTRL_VD_ENA];
  wire lbk3_ena = ctrl_q[CTRL_LBK3_ENA];
  wire [31:0] status_word = {key_cnt_q, 10'h000, TYPE_ENCODED_FLAG_O,
    IP_GROUP_DEST_FLAG_O, DEST_MAC_BROADCAST_FLAG_O,
    DEST_MAC_GROUP_FLAG_O, PORT_BITMAP_SELECTOR_O};
  wire [31:0] rd_mux =
    (addr_q == OFS_CTRL) ? {{(32-CTRL_W){1'b0}}, ctrl_q} :
    (addr_q == OFS_CUST12) ? {cust2_q, cust1_q} :
    (addr_q == OFS_CUST3) ? {16'h0000, cust3_q} :
    (addr_q == OFS_STATUS) ? status_word : 32'h0000_0000;

  // Address phase capture
  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else
    begin
      wr_q <= access && HWRITE_I;
      rd_q <= access && !HWRITE_I;
      if (access)
        addr_q <= HADDR_I[7:0];
    end
  end

  // Ready drops for one cycle on every read; response is always OKAY
  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
    begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      HRDATA_O <= 32'h0000_0000;
    end
    else
    begin
      HREADYOUT_O <= !(access && !HWRITE_I);
      if (rd_q)
        HRDATA_O <= rd_mux;
    end
  end

  // Configuration writes in the data phase; status is read only
  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
    begin
      ctrl_q <= CTRL_RESET;
      cust1_q <= CUST_RESET;
      cust2_q <= CUST_RESET;
      cust3_q <= CUST_RESET;
    end
    else if (wr_q)
    begin
      if (addr_q == OFS_CTRL)
        ctrl_q <= HWDATA_I[CTRL_W-1:0];
      if (addr_q == OFS_CUST12)
        {cust2_q, cust1_q} <= HWDATA_I;
      if (addr_q == OFS_CUST3)
        cust3_q <= HWDATA_I[15:0];
    end
  end

  // ---- Selector choice ----
  // Tested from the top value down so the highest qualifying one wins.
  wire phys_vd = (PHYS_PORT_I == FIRST_VD_PORT) ||
                 (PHYS_PORT_I == SECOND_VD_PORT);
  wire want_special = (CPU_INJECT_I && cpu_ena) || (phys_vd && vd_ena) ||
                      (LOOPBACK_I && lbk3_ena);
  wire is_masq = (INJECT_I && (SRC_PORT_I != PHYS_PORT_I)) ||
                 (PIPELINE_ACT_I == ACT_INJ_MASQ);
  wire [1:0] sel_d = want_special ? SEL_SPECIAL :
                     (is_masq && masq_ena) ? SEL_MASQ :
                     LOOPBACK_I ? SEL_LOOP : SEL_PHYS;

  // ---- Bitmap for each selector ----
  logic [PORT_CNT-1:0] special_map;
  always_comb
  begin
    special_map = '0;
    special_map[BM_FIRST_CPU] = PHYS_PORT_I == FIRST_CPU_PORT;
    special_map[BM_SECOND_CPU] = PHYS_PORT_I == SECOND_CPU_PORT;
    special_map[BM_FIRST_VD] = PHYS_PORT_I == FIRST_VD_PORT;
    special_map[BM_SECOND_VD] = PHYS_PORT_I == SECOND_VD_PORT;
    special_map[BM_SRC_HI:BM_SRC_LO] = SRC_PORT_I;
    special_map[BM_PT_HI:BM_PT_LO] = PIPELINE_PT_I;
    special_map[BM_ACT_HI:BM_ACT_LO] = PIPELINE_ACT_I;
    special_map[BM_RSVD] = 1'b0; // Reserved reads zero
  end

  wire [PORT_CNT-1:0] bitmap_d =
    (sel_d == SEL_SPECIAL) ? special_map :
    (sel_d == SEL_MASQ) ? port_bit(SRC_PORT_I) :
    (sel_d == SEL_LOOP) ? port_bit(LOOP_PORT_I) :
    port_bit(PHYS_PORT_I);

  // ---- Tag codes, one encoder per tag position ----
  logic [2:0][2:0] code_w;
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_tag
      tag_code_if tag ();
      assign tag.present = TAG_PRESENT_I[g];
      assign tag.tpid = TAG_TPID_I[g];
      assign code_w[g] = tag.code;
      tag_code_enc u_enc (
        .tag(tag.enc),
        .cust1_i(cust1_q),
        .cust2_i(cust2_q),
        .cust3_i(cust3_q)
      );
    end
  endgenerate

  // Outer tag: classified values replace the frame's when enabled, but an
  // untagged frame always keys on VLAN zero. Without classified values an
  // untagged frame has no control word, so its fields read zero.
  wire outer_tagged = code_w[0] != CODE_NONE;
  wire [15:0] outer_tci = use_cl ? {CL_PCP_I, CL_DEI_I, CL_VID_I} :
                          outer_tagged ? TAG_TCI_I[0] :
                          16'h0000;
  wire [15:0] tci1 = (code_w[1] != CODE_NONE) ? TAG_TCI_I[1] : 16'h0000;
  wire [15:0] tci2 = (code_w[2] != CODE_NONE) ? TAG_TCI_I[2] : 16'h0000;

  // ---- Flags ----
  wire bcast_d = &DEST_MAC_I;
  wire ip_group_dest_flag_d = (IS_IP4_I && (DIP_TOP_I[7:4] == IP4_MC_NIBBLE)) ||
                 (IS_IP6_I && (DIP_TOP_I == IP6_MC_BYTE));
  wire type_enc_d = ETYPE_I >= TYPE_MIN;

  // Key register: everything lands one cycle after the frame valid
  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
    begin
      KEY_VALID_O <= 1'b0;
      INGRESS_PORT_BITMAP_O <= '0;
      PORT_BITMAP_SELECTOR_O <= SEL_PHYS;
      DEST_MAC_GROUP_FLAG_O <= 1'b0;
      DEST_MAC_BROADCAST_FLAG_O <= 1'b0;
      OUTER_TAG_PROTO_CODE_O <= CODE_NONE;
      {OUTER_TAG_PRIORITY_O, OUTER_TAG_DROP_ELIGIBLE_O} <= 4'h0;
      OUTER_TAG_VLAN_ID_O <= 12'h000;
      SECOND_TAG_PROTO_CODE_O <= CODE_NONE;
      {SECOND_TAG_PRIORITY_O, SECOND_TAG_DROP_ELIGIBLE_O,
        SECOND_TAG_VLAN_ID_O} <= 16'h0000;
      THIRD_TAG_PROTO_CODE_O <= CODE_NONE;
      {THIRD_TAG_PRIORITY_O, THIRD_TAG_DROP_ELIGIBLE_O,
        THIRD_TAG_VLAN_ID_O} <= 16'h0000;
      DEST_MAC_FIELD_O <= 48'h0000_0000_0000;
      SRC_MAC_FIELD_O <= 48'h0000_0000_0000;
      IP_GROUP_DEST_FLAG_O <= 1'b0;
      TYPE_ENCODED_FLAG_O <= 1'b0;
      key_cnt_q <= 16'h0000;
    end
    else
    begin
      KEY_VALID_O <= FRAME_VALID_I;
      if (FRAME_VALID_I)
      begin
        key_cnt_q <= key_cnt_q + 16'h0001;
        INGRESS_PORT_BITMAP_O <= bitmap_d;
        PORT_BITMAP_SELECTOR_O <= sel_d;
        DEST_MAC_GROUP_FLAG_O <= DEST_MAC_I[MAC_GROUP_BIT];
        DEST_MAC_BROADCAST_FLAG_O <= bcast_d;
        OUTER_TAG_PROTO_CODE_O <= code_w[0];
        {OUTER_TAG_PRIORITY_O, OUTER_TAG_DROP_ELIGIBLE_O} <=
          outer_tci[15:12];
        OUTER_TAG_VLAN_ID_O <= outer_tagged ? outer_tci[11:0] :
                               12'h000;
        SECOND_TAG_PROTO_CODE_O <= code_w[1];
        {SECOND_TAG_PRIORITY_O, SECOND_TAG_DROP_ELIGIBLE_O,
          SECOND_TAG_VLAN_ID_O} <= tci1;
        THIRD_TAG_PROTO_CODE_O <= code_w[2];
        {THIRD_TAG_PRIORITY_O, THIRD_TAG_DROP_ELIGIBLE_O,
          THIRD_TAG_VLAN_ID_O} <= tci2;
        DEST_MAC_FIELD_O <= DEST_MAC_I;
        SRC_MAC_FIELD_O <= SRC_MAC_I;
        IP_GROUP_DEST_FLAG_O <= ip_group_dest_flag_d;
        TYPE_ENCODED_FLAG_O <= type_enc_d;
      end
    end
  end

  // ---- Checks ----
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RESET_I);

  AST_PHYS_MAP: assert property (
    FRAME_VALID_I && !LOOPBACK_I && !want_special && !is_masq |=>
      INGRESS_PORT_BITMAP_O == port_bit($past(PHYS_PORT_I)))
    else $error("physical port bitmap wrong");

  AST_LOOP_SEL: assert property (
    FRAME_VALID_I && LOOPBACK_I && !want_special &&
      !(is_masq && masq_ena) |=>
      PORT_BITMAP_SELECTOR_O == SEL_LOOP &&
      INGRESS_PORT_BITMAP_O == port_bit($past(LOOP_PORT_I)))
    else $error("loopback selector or bitmap wrong");

  AST_TOP_SEL: assert property (
    FRAME_VALID_I && want_special |=>
      PORT_BITMAP_SELECTOR_O == SEL_SPECIAL)
    else $error("highest selector not taken");

  AST_SPECIAL_MAP: assert property (
    FRAME_VALID_I && want_special |=>
      !INGRESS_PORT_BITMAP_O[BM_RSVD] &&
      INGRESS_PORT_BITMAP_O[BM_PT_HI:BM_PT_LO] == $past(PIPELINE_PT_I) &&
      INGRESS_PORT_BITMAP_O[BM_SRC_HI:BM_SRC_LO] == $past(SRC_PORT_I))
    else $error("special bitmap layout wrong");

  AST_GROUP: assert property (
    KEY_VALID_O |->
      DEST_MAC_GROUP_FLAG_O == DEST_MAC_FIELD_O[MAC_GROUP_BIT])
    else $error("group flag does not follow MAC bit");

  AST_BCAST: assert property (
    KEY_VALID_O |-> DEST_MAC_BROADCAST_FLAG_O == (&DEST_MAC_FIELD_O))
    else $error("broadcast flag wrong");

  AST_NO_CODE23: assert property (
    KEY_VALID_O |-> OUTER_TAG_PROTO_CODE_O[2:1] != 2'h1 &&
      SECOND_TAG_PROTO_CODE_O[2:1] != 2'h1 &&
      THIRD_TAG_PROTO_CODE_O[2:1] != 2'h1)
    else $error("undefined tag code produced");

  AST_UNTAG_VID: assert property (
    FRAME_VALID_I && !TAG_PRESENT_I[0] |=>
      OUTER_TAG_PROTO_CODE_O == CODE_NONE && OUTER_TAG_VLAN_ID_O == 12'h000)
    else $error("untagged frame has nonzero VLAN");

  AST_TYPE_ENC: assert property (
    FRAME_VALID_I |=> TYPE_ENCODED_FLAG_O == ($past(ETYPE_I) >= TYPE_MIN))
    else $error("type encoded flag wrong");
endmodule : key_field_builder

`default_nettype wire

/* key_sink_model.sv */
/*
  Lookup-stage stand-in: collects every key the builder hands over.
  Assumes the key outputs arrive packed into one vector with a
  valid that is high one cycle for each key, back to back in a burst.
*/
`default_nettype none

module key_sink_model
(
  input wire logic clk_i,
  input wire logic valid_i,
  input wire logic [211:0] key_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [211:0] got_q[$];

  // Valid can stand several cycles back to back; each edge that sees it high takes one key
  always @(posedge clk_i)
  begin
    if (valid_i === 1'b1)
      got_q.push_back(key_i);
  end
endmodule : key_sink_model

`default_nettype wire

/* testbench.sv */
/*
  Self-checking bench for the key field builder: a reference model
  predicts each key and the sink model collects what the design built.
  Assumes the design's default port numbers for CPU and virtual ports.
*/
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import key_build_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  wire logic [31:0] hrdata;
  wire logic hready;
  wire logic hresp;
  wire logic kv;
  wire logic [211:0] key;
  logic fv, lb, inj, cinj, cld, ip4, ip6;
  logic [5:0] phys, lport, sport;
  logic [2:0] tpres, act, clp;
  logic [4:0] pt;
  logic [11:0] clv;
  logic [15:0] etype;
  logic [7:0] dip;
  logic [47:0] dmac, smac;
  logic [2:0][15:0] tpid, tci;
  logic [4:0] ctrl;
  logic [15:0] cust [3];
  logic [211:0] exp_q[$];
  logic [211:0] last, g, w;
  int n_errors = 0;
  int samples_checked = 0;

  // Half-period toggle gives the 25 ns core clock
  always #12.5 clk = ~clk;

  key_field_builder key_field_builder_inst (
    .CLOCK_I(clk), .RESET_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .FRAME_VALID_I(fv),
    .PHYS_PORT_I(phys), .LOOPBACK_I(lb), .LOOP_PORT_I(lport),
    .INJECT_I(inj), .CPU_INJECT_I(cinj), .SRC_PORT_I(sport),
    .PIPELINE_PT_I(pt), .PIPELINE_ACT_I(act), .DEST_MAC_I(dmac),
    .SRC_MAC_I(smac), .TAG_PRESENT_I(tpres), .TAG_TPID_I(tpid),
    .TAG_TCI_I(tci), .CL_PCP_I(clp), .CL_DEI_I(cld), .CL_VID_I(clv),
    .ETYPE_I(etype), .IS_IP4_I(ip4), .IS_IP6_I(ip6), .DIP_TOP_I(dip),
    .KEY_VALID_O(kv), .INGRESS_PORT_BITMAP_O(key[211:159]),
    .PORT_BITMAP_SELECTOR_O(key[158:157]),
    .DEST_MAC_GROUP_FLAG_O(key[156]),
    .DEST_MAC_BROADCAST_FLAG_O(key[155]),
    .OUTER_TAG_PROTO_CODE_O(key[154:152]),
    .OUTER_TAG_PRIORITY_O(key[151:149]),
    .OUTER_TAG_DROP_ELIGIBLE_O(key[148]),
    .OUTER_TAG_VLAN_ID_O(key[147:136]),
    .SECOND_TAG_PROTO_CODE_O(key[135:133]),
    .SECOND_TAG_PRIORITY_O(key[132:130]),
    .SECOND_TAG_DROP_ELIGIBLE_O(key[129]),
    .SECOND_TAG_VLAN_ID_O(key[128:117]),
    .THIRD_TAG_PROTO_CODE_O(key[116:114]),
    .THIRD_TAG_PRIORITY_O(key[113:111]),
    .THIRD_TAG_DROP_ELIGIBLE_O(key[110]),
    .THIRD_TAG_VLAN_ID_O(key[109:98]), .DEST_MAC_FIELD_O(key[97:50]),
    .SRC_MAC_FIELD_O(key[49:2]), .IP_GROUP_DEST_FLAG_O(key[1]),
    .TYPE_ENCODED_FLAG_O(key[0])
  );

  key_sink_model key_sink_model_inst (
    .clk_i(clk),
    .valid_i(kv),
    .key_i(key)
  );

  task automatic check(input string name, input logic [211:0] seen,
                       input logic [211:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, want, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("Checks made %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  // One single word transfer; waits on ready, never on a fixed count
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    check("response", hresp, 1'b0);
    hsel <= 1'b0;
  endtask : bus

  // Reference model of one key, built from the inputs now on the pins
  function automatic logic [211:0] exp_key();
    logic [52:0] bm;
    logic [1:0] s;
    logic [5:0] p;
    logic [2:0] c;
    logic [18:0] f [3];
    bm = '0;
    if (cinj & ctrl[2] | (phys == 6'h37 | phys == 6'h38) & ctrl[3]
        | lb & ctrl[4])
      s = SEL_SPECIAL;
    else if (ctrl[1] & (inj & sport != phys | act == 3'h1))
      s = SEL_MASQ;
    else
      s = {1'b0, lb};
    p = s == SEL_PHYS ? phys : s == SEL_LOOP ? lport : sport;
    if (s == SEL_SPECIAL)
      bm = {1'b0, act, pt, 34'h0, sport, phys == 6'h38, phys == 6'h37,
            phys == 6'h36, phys == 6'h35};
    else if (p < PORT_CNT)
      bm[p] = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      c = !tpres[i] ? CODE_NONE : tpid[i] == TPID_CTAG ? CODE_CTAG :
          tpid[i] == TPID_STAG ? CODE_STAG : tpid[i] == cust[0] ?
          CODE_CUST1 : tpid[i] == cust[1] ? CODE_CUST2 :
          tpid[i] == cust[2] ? CODE_CUST3 : CODE_NONE;
      f[i] = c != CODE_NONE ? {c, tci[i]} : 19'h0;
    end
    if (ctrl[0])
      f[0][15:0] = {clp, cld, f[0][18:16] != CODE_NONE ? clv : 12'h0};
    return {bm, s, dmac[MAC_GROUP_BIT], &dmac, f[0], f[1], f[2], dmac,
            smac, ip4 & dip[7:4] == IP4_MC_NIBBLE | ip6 & dip == IP6_MC_BYTE,
            etype >= TYPE_MIN};
  endfunction : exp_key

  // Random frame held with valid for one cycle; back to back when repeated
  task automatic send();
    logic [5:0] p;
    logic [15:0] opt [6];
    @(posedge clk);
    p = 6'($urandom_range(56, 0));
    opt = '{TPID_CTAG, TPID_STAG, cust[0], cust[1], cust[2], 16'($urandom)};
    phys <= p;
    sport <= $urandom_range(1, 0) ? p : 6'($urandom);
    lport <= 6'($urandom_range(55, 0));
    {lb, inj, ip4, ip6, cld} <= 5'($urandom);
    cinj <= $urandom_range(3, 0) == 0;
    {act, pt, clp} <= 11'($urandom);
    clv <= 12'($urandom);
    smac <= {16'($urandom), $urandom};
    dmac <= $urandom_range(3, 0) == 0 ? '1 : {16'($urandom), $urandom};
    tpres <= 3'($urandom);
    for (int i = 0; i < 3; i++)
    begin
      tpid[i] <= opt[$urandom_range(5, 0)];
      tci[i] <= 16'($urandom);
    end
    etype <= 16'h05ff + 16'($urandom_range(1, 0));
    dip <= $urandom_range(1, 0) ? 8'hff : {4'he ^ 4'($urandom), 4'h3};
    fv <= 1'b1;
    #1;
    last = exp_key();
    exp_q.push_back(last);
  endtask : send

  // Watchdog: the run needs a little under 700 cycles
  initial
  begin
    #(25 * 5000);
    n_errors++;
    end_sim();
  end

  // Main sequence: reset values, register setup, every control mix
  initial
  begin
    logic [31:0] r;
    {fv, lb, inj, cinj, cld, ip4, ip6, tpres, act, pt, clp, ctrl} = '0;
    {phys, lport, sport, clv, etype, dip, dmac, smac, tpid, tci} = '0;
    void'($urandom(24));
    cust = '{16'h9100, 16'h9200, 16'h9300};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    check("key at reset", key, '0);
    for (int a = 0; a < 20; a += 4)
    begin
      bus(1'b0, 8'(a), 32'h0, r);
      check("register at reset", r, 32'h0);
    end
    bus(1'b1, OFS_CUST12, {cust[1], cust[0]}, r);
    bus(1'b1, OFS_CUST3, {16'h0, cust[2]}, r);
    bus(1'b1, OFS_STATUS, 32'hffffffff, r);
    bus(1'b1, 8'h10, 32'hffffffff, r);
    bus(1'b0, OFS_CUST12, 32'h0, r);
    check("custom pair", r, {cust[1], cust[0]});
    bus(1'b0, 8'h10, 32'h0, r);
    check("unmapped", r, 32'h0);
    for (int t = 0; t < 32; t++)
    begin
      ctrl = 5'(t);
      bus(1'b1, OFS_CTRL, 32'(t), r);
      bus(1'b0, OFS_CTRL, 32'h0, r);
      check("control", r, 32'(t));
      repeat (8) send();
      @(posedge clk);
      fv <= 1'b0;
      repeat (3) @(posedge clk);
      check("key count", key_sink_model_inst.got_q.size(), exp_q.size());
      while (exp_q.size() > 0)
      begin
        g = key_sink_model_inst.got_q.pop_front();
        w = exp_q.pop_front();
        check("selector", g[158:157], w[158:157]);
        check("map", g[211:159], w[211:159]);
        check("l2 flags", g[156:155], w[156:155]);
        check("outer tag", g[154:136], w[154:136]);
        check("inner tags", g[135:98], w[135:98]);
        check("macs", g[97:2], w[97:2]);
        check("l3 flags", g[1:0], w[1:0]);
      end
    end
    bus(1'b0, OFS_STATUS, 32'h0, r);
    check("status", r, {16'h0100, 10'h0, last[0], last[1], last[155],
                        last[156], last[158:157]});
    // Reset again in mid-run: key and counters must clear
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("key after reset", key, '0);
    bus(1'b0, OFS_STATUS, 32'h0, r);
    check("status after reset", r, 32'h0);
    end_sim();
  end
endmodule : testbench

`default_nettype wire
